// >>> src/mmd_pkg.sv
package mmd_pkg;

  // Operating modes, chosen from the two mode pins
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_EXPANDED,
    MODE_BOOT,
    MODE_TEST
  } mmd_mode_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mmd_reg_req_t;

  // Core bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic valid;
    logic write;
    logic vector;
    logic inst_start;
  } mmd_core_req_t;

  // Which resource answers an access
  typedef struct packed {
    logic regs;
    logic ram;
    logic boot;
    logic rom;
    logic ext;
  } mmd_sel_t;

  // Drive of one eight-bit port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } mmd_port_t;

  // Register offsets on the register port
  localparam logic [7:0] REG_MAP = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;

  // Field positions and reset values
  localparam int CFG_ROM_EN_BIT = 0;
  localparam logic [7:0] MAP_RESET = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hff;

  // Mapping register write window, in E-clock cycles
  localparam int MAP_WINDOW_CYCLES = 64;
  localparam logic [6:0] MAP_WINDOW = 7'(MAP_WINDOW_CYCLES);

  // Resource placement
  localparam logic [15:0] ROM_BASE = 16'hc000;
  localparam int ROM_ADDR_BITS = 14;
  localparam logic [15:0] BOOT_BASE = 16'hbf00;
  localparam int BOOT_ADDR_BITS = 8;
  localparam int RAM_ADDR_BITS = 9;
  localparam int REGS_ADDR_BITS = 7;
  localparam int BLOCK_SHIFT = 12;

  // Vector areas
  localparam logic [15:0] VEC_NORMAL = 16'hffc0;
  localparam logic [15:0] VEC_ALT = 16'hbfc0;
  localparam int VEC_ADDR_BITS = 6;

endpackage

// >>> src/mmd_window_match.sv
`timescale 1ns/1ps

// Flags an address inside an aligned window of 2**SIZE_BITS bytes
module mmd_window_match #(
  parameter int SIZE_BITS = 8
) (
  // Window
  input wire logic i_enable,
  input wire logic [15:0] i_base,
  // Address under test
  input wire logic [15:0] i_addr,
  // Result
  output logic o_hit
);

  // Base is assumed aligned, so only the upper bits are compared
  assign o_hit = i_enable && (i_addr[15:SIZE_BITS] == i_base[15:SIZE_BITS]);

endmodule

// >>> src/mmd_memory_map_decoder.sv
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps

module mmd_memory_map_decoder (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Mode pins
  input wire logic i_mode_select_a,
  input wire logic i_mode_select_b,
  // Core bus
  input wire mmd_pkg::mmd_core_req_t i_core,
  // Register port
  input wire mmd_pkg::mmd_reg_req_t i_reg,
  output logic [7:0] o_reg_rdata,
  // External bus handshake
  input wire logic i_memory_ready_input,
  // General-purpose drive of ports B, C and F
  input wire mmd_pkg::mmd_port_t i_gpio_b,
  input wire mmd_pkg::mmd_port_t i_gpio_c,
  input wire mmd_pkg::mmd_port_t i_gpio_f,
  // Port pins
  output mmd_pkg::mmd_port_t o_port_b,
  output mmd_pkg::mmd_port_t o_port_c,
  output mmd_pkg::mmd_port_t o_port_f,
  // Decode result
  output mmd_pkg::mmd_sel_t o_sel,
  output logic [15:0] o_eff_addr,
  output logic o_access_ready,
  // Mode and bus state
  output mmd_pkg::mmd_mode_t o_mode,
  output logic o_bus_mode,
  // Open-drain instruction fetch marker
  output logic o_instruction_fetch_marker,
  output logic o_instruction_fetch_marker_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  mmd_pkg::mmd_mode_t mode;
  logic mode_valid;
  logic rom_present_enable;
  logic [7:0] map;
  logic map_written;
  logic [6:0] window_count;
  logic window_open;
  logic special;
  logic expanded_bus;
  logic map_wr_ok;
  logic [15:0] next_eff_addr;
  logic vector_alt;
  logic boot_on;
  logic hit_rom;
  logic hit_boot;
  logic hit_ram;
  logic hit_regs;
  logic [15:0] ram_base;
  logic [15:0] regs_base;
  mmd_pkg::mmd_sel_t next_sel;
  logic [7:0] next_rdata;
  logic [7:0] status_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Mode capture

  // Flops under async reset may only take constants, so the pins are
  // caught on the first edge after release.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode <= mmd_pkg::MODE_SINGLE;
      mode_valid <= 1'b0;
    end else if (!mode_valid) begin
      mode_valid <= 1'b1;
      unique case ({i_mode_select_b, i_mode_select_a})
        2'b10: mode <= mmd_pkg::MODE_SINGLE;
        2'b11: mode <= mmd_pkg::MODE_EXPANDED;
        2'b00: mode <= mmd_pkg::MODE_BOOT;
        2'b01: mode <= mmd_pkg::MODE_TEST;
      endcase
    end
  end

  always_comb begin
    special = (mode == mmd_pkg::MODE_BOOT) || (mode == mmd_pkg::MODE_TEST);
    expanded_bus = mode_valid && ((mode == mmd_pkg::MODE_EXPANDED) ||
                                  (mode == mmd_pkg::MODE_TEST));
    boot_on = mode_valid && (mode == mmd_pkg::MODE_BOOT);
  end

  ////////////////////////////////////////////////////////////////////////////
  // ROM enable

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rom_present_enable <= 1'b0;
    end else if (!mode_valid) begin
      // Reset value follows the mode being caught in this same edge
      rom_present_enable <=
        !(i_mode_select_b && i_mode_select_a);
    end else if (i_reg.wr && i_reg.addr == mmd_pkg::REG_CFG && special) begin
      // Normal modes silently drop the write
      rom_present_enable <=
        i_reg.wdata[mmd_pkg::CFG_ROM_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mapping register

  // Window counter saturates so it never wraps back open
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      window_count <= 7'h00;
    end else if (mode_valid && window_open) begin
      window_count <= window_count + 7'h01;
    end
  end

  assign window_open = (window_count < mmd_pkg::MAP_WINDOW);

  always_comb begin
    if (!mode_valid) begin
      map_wr_ok = 1'b0;
    end else if (special) begin
      map_wr_ok = 1'b1;
    end else begin
      map_wr_ok = window_open && !map_written;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      map <= mmd_pkg::MAP_RESET;
      map_written <= 1'b0;
    end else if (i_reg.wr && i_reg.addr == mmd_pkg::REG_MAP) begin
      if (map_wr_ok) begin
        map <= i_reg.wdata;
        map_written <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Upper nibble places the RAM, lower nibble the register block
  always_comb begin
    ram_base = {map[7:4], 12'h000};
    regs_base = {map[3:0], 12'h000};
  end

  // Vector redirect only when the fetch falls in the normal vector area
  always_comb begin
    vector_alt = mode_valid && special && i_core.vector &&
      (i_core.addr[15:mmd_pkg::VEC_ADDR_BITS] ==
       mmd_pkg::VEC_NORMAL[15:mmd_pkg::VEC_ADDR_BITS]);
    if (vector_alt) begin
      next_eff_addr = {mmd_pkg::VEC_ALT[15:mmd_pkg::VEC_ADDR_BITS],
                       i_core.addr[mmd_pkg::VEC_ADDR_BITS-1:0]};
    end else begin
      next_eff_addr = i_core.addr;
    end
  end

  mmd_window_match #(
    .SIZE_BITS(mmd_pkg::ROM_ADDR_BITS)
  ) u_rom_match (
    .i_enable(mode_valid && rom_present_enable),
    .i_base(mmd_pkg::ROM_BASE),
    .i_addr(next_eff_addr),
    .o_hit(hit_rom)
  );

  mmd_window_match #(
    .SIZE_BITS(mmd_pkg::BOOT_ADDR_BITS)
  ) u_boot_match (
    .i_enable(boot_on),
    .i_base(mmd_pkg::BOOT_BASE),
    .i_addr(next_eff_addr),
    .o_hit(hit_boot)
  );

  mmd_window_match #(
    .SIZE_BITS(mmd_pkg::RAM_ADDR_BITS)
  ) u_ram_match (
    .i_enable(mode_valid),
    .i_base(ram_base),
    .i_addr(next_eff_addr),
    .o_hit(hit_ram)
  );

  mmd_window_match #(
    .SIZE_BITS(mmd_pkg::REGS_ADDR_BITS)
  ) u_regs_match (
    .i_enable(mode_valid),
    .i_base(regs_base),
    .i_addr(next_eff_addr),
    .o_hit(hit_regs)
  );

  // Registers over RAM over bootstrap ROM over ROM over external
  always_comb begin
    next_sel = '0;
    if (i_core.valid && mode_valid) begin
      if (hit_regs) begin
        next_sel.regs = 1'b1;
      end else if (hit_ram) begin
        next_sel.ram = 1'b1;
      end else if (hit_boot) begin
        next_sel.boot = 1'b1;
      end else if (hit_rom) begin
        next_sel.rom = 1'b1;
      end else if (expanded_bus) begin
        next_sel.ext = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sel <= '0;
      o_eff_addr <= 16'h0000;
    end else begin
      o_sel <= next_sel;
      o_eff_addr <= next_eff_addr;
    end
  end

  // Internal resources never wait; external ones wait for memory ready
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_access_ready <= 1'b0;
    end else begin
      o_access_ready <= next_sel.ext ? i_memory_ready_input : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port pins

  // Bus duty or general purpose, chosen by mode
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_port_b <= '0;
      o_port_f <= '0;
      o_bus_mode <= 1'b0;
    end else if (expanded_bus) begin
      o_port_b.out <= next_eff_addr[15:8];
      o_port_b.oe <= mmd_pkg::ALL_ONES;
      o_port_f.out <= next_eff_addr[7:0];
      o_port_f.oe <= mmd_pkg::ALL_ONES;
      o_bus_mode <= 1'b1;
    end else begin
      o_port_b <= i_gpio_b;
      o_port_f <= i_gpio_f;
      o_bus_mode <= 1'b0;
    end
  end

  // Data bus is driven only for external writes, else released to read
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_port_c <= '0;
    end else if (expanded_bus) begin
      o_port_c.out <= i_core.wdata;
      o_port_c.oe <= (next_sel.ext && i_core.write) ?
                     mmd_pkg::ALL_ONES : mmd_pkg::ZERO_BYTE;
    end else begin
      o_port_c <= i_gpio_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction fetch marker

  // Open drain: only ever pulls low, released until the mode is known
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_instruction_fetch_marker <= 1'b0;
      o_instruction_fetch_marker_oe <= 1'b0;
    end else begin
      o_instruction_fetch_marker <= 1'b0;
      o_instruction_fetch_marker_oe <= mode_valid && i_core.inst_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read

  always_comb begin
    status_byte = {3'b000, map_written, window_open, mode_valid, mode};
  end

  always_comb begin
    next_rdata = mmd_pkg::ZERO_BYTE;
    unique case (i_reg.addr)
      mmd_pkg::REG_MAP: next_rdata = map;
      mmd_pkg::REG_CFG: next_rdata = {7'h00, rom_present_enable};
      mmd_pkg::REG_STATUS: next_rdata = status_byte;
      default: next_rdata = mmd_pkg::ZERO_BYTE;
    endcase
  end

  // Read data stand for the one cycle after the strobe only
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reg_rdata <= mmd_pkg::ZERO_BYTE;
    end else if (i_reg.rd) begin
      o_reg_rdata <= next_rdata;
    end else begin
      o_reg_rdata <= mmd_pkg::ZERO_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode output

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mode <= mmd_pkg::MODE_SINGLE;
    end else begin
      o_mode <= mode;
    end
  end

endmodule

// >>> verif/mmd_properties.sv
`timescale 1ns/1ps
module mmd_properties (
  // Watched ports
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire mmd_pkg::mmd_core_req_t i_core,
  input wire mmd_pkg::mmd_port_t i_gpio_b,
  input wire mmd_pkg::mmd_port_t o_port_b,
  input wire mmd_pkg::mmd_sel_t o_sel,
  input wire logic [15:0] o_eff_addr,
  input wire logic o_access_ready,
  input wire mmd_pkg::mmd_mode_t o_mode,
  input wire logic o_bus_mode,
  input wire logic o_instruction_fetch_marker_oe
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // Edges since reset; outputs settle only after mode capture
  logic [1:0] n_up;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      n_up <= 2'h0;
    end else if (n_up != 2'h3) begin
      n_up <= n_up + 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////
  property p_rom;
    o_sel.rom |-> o_eff_addr[15:14] == 2'h3;
  endproperty
  a_rom: assert property (p_rom)
    else $error("rom select outside top range");
  property p_boot;
    o_sel.boot |-> o_mode == mmd_pkg::MODE_BOOT && o_eff_addr[15:8] == 8'hbf;
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot select wrong");
  property p_vec;
    i_core.valid && i_core.vector && i_core.addr[15:6] == 10'h3ff
      && o_mode[1] |=> o_eff_addr == {10'h2ff, $past(i_core.addr[5:0])};
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector not redirected");
  property p_ready;
    n_up == 2'h3 && !o_sel.ext |-> o_access_ready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("internal access not ready");
  property p_ext;
    o_sel.ext |-> o_bus_mode;
  endproperty
  a_ext: assert property (p_ext)
    else $error("external access outside bus modes");
  property p_bus;
    n_up == 2'h3 |-> o_bus_mode == o_mode[0];
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus duty does not follow mode");
  property p_gpio;
    n_up == 2'h3 && !o_bus_mode |-> o_port_b == $past(i_gpio_b);
  endproperty
  a_gpio: assert property (p_gpio)
    else $error("port b not general purpose");
  property p_mark;
    n_up == 2'h3 |-> o_instruction_fetch_marker_oe == $past(i_core.inst_start);
  endproperty
  a_mark: assert property (p_mark)
    else $error("fetch marker wrong");
  property p_mode;
    n_up == 2'h3 |-> $stable(o_mode);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode changed after capture");
  property p_onehot;
    $onehot0(o_sel);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("more than one resource selected");
  c_boot: cover property (o_sel.boot);
  c_wait: cover property (o_sel.ext && !o_access_ready);
  c_vec: cover property (o_sel.ext && o_eff_addr[15:6] == 10'h2ff);
endmodule

// >>> verif/mmd_ext_mem_model.sv
`timescale 1ns/1ps
module mmd_ext_mem_model (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Access
  input wire logic i_ext_sel,
  input wire logic i_slow,
  output logic o_ready
);
  // Slow memory holds ready low two cycles per access
  logic [1:0] wait_cnt;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_cnt <= 2'h0;
    end else if (!i_ext_sel) begin
      wait_cnt <= 2'h0;
    end else if (wait_cnt != 2'h2) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
  assign o_ready = !i_slow || wait_cnt == 2'h2;
endmodule

// >>> verif/tb_memory_map_decoder.sv
`timescale 1ns/1ps
module tb_memory_map_decoder;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ma = 1'b0;
  logic mb = 1'b0;
  logic slow = 1'b0;
  mmd_pkg::mmd_core_req_t core = '0;
  mmd_pkg::mmd_reg_req_t rreq = '0;
  mmd_pkg::mmd_port_t gb = '0;
  mmd_pkg::mmd_port_t gc = '0;
  mmd_pkg::mmd_port_t gf = '0;
  mmd_pkg::mmd_port_t pb, pc, pf;
  mmd_pkg::mmd_sel_t sel;
  mmd_pkg::mmd_mode_t mode, m;
  logic [15:0] eff;
  logic [7:0] rdata, rd, map;
  logic rdy, acc_rdy, bus, mk, mk_oe, rom;
  int n_errors = 0;
  int tests_run = 0;
  int seed = 32'h3159940e;
  always #50 clk = ~clk;
  mmd_memory_map_decoder mmd_memory_map_decoder_i (
    .i_ref_clk(clk), .i_rstn(rstn),
    .i_mode_select_a(ma), .i_mode_select_b(mb),
    .i_core(core), .i_reg(rreq), .o_reg_rdata(rdata),
    .i_memory_ready_input(rdy),
    .i_gpio_b(gb), .i_gpio_c(gc), .i_gpio_f(gf),
    .o_port_b(pb), .o_port_c(pc), .o_port_f(pf),
    .o_sel(sel), .o_eff_addr(eff), .o_access_ready(acc_rdy),
    .o_mode(mode), .o_bus_mode(bus),
    .o_instruction_fetch_marker(mk),
    .o_instruction_fetch_marker_oe(mk_oe)
  );
  mmd_ext_mem_model mmd_ext_mem_model_i (
    .i_ref_clk(clk), .i_rstn(rstn), .i_ext_sel(sel.ext),
    .i_slow(slow), .o_ready(rdy)
  );
  ////////////////////////////////////////////////////////////////////
  function logic [15:0] x_eff(logic [15:0] a, logic v);
    return (v && m[1] && a[15:6] == 10'h3ff) ? {10'h2ff, a[5:0]} : a;
  endfunction
  // Priority: registers, RAM, boot ROM, ROM, external
  function mmd_pkg::mmd_sel_t x_sel(logic [15:0] a);
    x_sel = '0;
    if (a[15:7] == {map[3:0], 5'h0}) x_sel.regs = 1'b1;
    else if (a[15:9] == {map[7:4], 3'h0}) x_sel.ram = 1'b1;
    else if (m == mmd_pkg::MODE_BOOT && a[15:8] == 8'hbf) x_sel.boot = 1'b1;
    else if (rom && a[15:14] == 2'h3) x_sel.rom = 1'b1;
    else x_sel.ext = m[0];
  endfunction
  task chk(logic [15:0] got, logic [15:0] want);
    tests_run++;
    if (got !== want) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, want);
    end
  endtask
  task acc(logic [15:0] a, logic v);
    mmd_pkg::mmd_sel_t xs;
    logic [15:0] xe;
    logic [7:0] xc;
    @(posedge clk);
    core <= '{a, 8'($random(seed)), 1'b1, 1'($random(seed)), v,
      1'($random(seed))};
    gb <= 16'($random(seed));
    gc <= 16'($random(seed));
    gf <= 16'($random(seed));
    slow <= 1'($random(seed));
    @(posedge clk);
    core.valid <= 1'b0;
    #1;
    xe = x_eff(a, v);
    xs = x_sel(xe);
    xc = (xs.ext && core.write) ? 8'hff : 8'h00;
    chk(16'(sel), 16'(xs));
    chk(eff, xe);
    chk(16'(acc_rdy), 16'(!xs.ext || !slow));
    chk(pb, m[0] ? {xe[15:8], 8'hff} : 16'(gb));
    chk(pf, m[0] ? {xe[7:0], 8'hff} : 16'(gf));
    chk(pc, m[0] ? {core.wdata, xc} : 16'(gc));
    chk(16'({mk, mk_oe}), 16'({1'b0, core.inst_start}));
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    rreq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    rreq <= '0;
  endtask
  task rdr(logic [7:0] a);
    @(posedge clk);
    rreq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    rreq <= '0;
    #1;
    rd = rdata;
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test;
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      rstn <= 1'b0;
      m = mmd_pkg::mmd_mode_t'(i);
      mb <= ~m[1];
      ma <= m[0];
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      map = 8'h01;
      rom = m != mmd_pkg::MODE_EXPANDED;
      chk(16'(mode), 16'(m));
      rdr(mmd_pkg::REG_MAP);
      chk(16'(rd), 16'h0001);
      rdr(mmd_pkg::REG_CFG);
      chk(16'(rd[0]), 16'(rom));
      acc(16'h01ff, 1'b0);
      acc(16'h0200, 1'b0);
      acc(16'hc000, 1'b0);
      acc(16'hbf00, 1'b0);
      acc(16'hfffe, 1'b1);
      wr(mmd_pkg::REG_MAP, 8'hcc);
      map = 8'hcc;
      acc(16'hc07f, 1'b0);
      acc(16'hc1ff, 1'b0);
      wr(mmd_pkg::REG_MAP, 8'h01);
      if (m[1]) map = 8'h01;
      rdr(mmd_pkg::REG_MAP);
      chk(16'(rd), 16'(map));
      wr(mmd_pkg::REG_CFG, {7'h00, !rom});
      if (m[1]) rom = !rom;
      rdr(mmd_pkg::REG_CFG);
      chk(16'(rd[0]), 16'(rom));
      acc(16'hfff0, 1'b0);
      rdr(8'h7f);
      chk(16'(rd), 16'h0000);
      repeat (40) acc(16'($random(seed)), 1'($random(seed)));
      rdr(mmd_pkg::REG_STATUS);
      chk(16'(rd), 16'({6'h05, 2'(m)}));
    end
    end_of_test;
  end
endmodule
bind mmd_memory_map_decoder mmd_properties mmd_properties_i (
  .i_ref_clk, .i_rstn, .i_core, .i_gpio_b, .o_port_b, .o_sel,
  .o_eff_addr, .o_access_ready, .o_mode, .o_bus_mode,
  .o_instruction_fetch_marker_oe
);
